// ---- scs_ost.sv ----
`timescale 1ns/100ps
`default_nettype none
module scs_ost #(
  parameter int unsigned PERIODS = scs_pkg::OST_PERIODS
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic en_i,
  // synchronised oscillator level and restart
  input  wire logic osc_sync_i,
  input  wire logic restart_i,
  // count complete
  output logic      done_o
);
  import scs_pkg::*;

  localparam int unsigned CNT_W = $clog2(PERIODS + 1);
  localparam logic [CNT_W-1:0] CNT_END = CNT_W'(PERIODS);

  logic             osc_prev_reg;
  logic             osc_prev_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;

  // one count per rising edge of the oscillator, saturating at the end
  always_comb
  begin
    osc_prev_next = osc_sync_i;
    cnt_next      = cnt_reg;
    if (restart_i)
      cnt_next = '0;
    else if (osc_sync_i && !osc_prev_reg && cnt_reg != CNT_END)
      cnt_next = cnt_reg + CNT_W'(1);
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      osc_prev_reg <= 1'b0;
      cnt_reg      <= '0;
    end
    else if (en_i)
    begin
      osc_prev_reg <= osc_prev_next;
      cnt_reg      <= cnt_next;
    end
  end

  // ready only after the full count since power-up or restart
  assign done_o = (cnt_reg == CNT_END);

endmodule : scs_ost
`default_nettype wire

// ---- scs_pkg.sv ----
package scs_pkg;

  // field widths
  localparam int unsigned SRC_W  = 3;
  localparam int unsigned DIV_W  = 4;
  localparam int unsigned FRQ_W  = 4;
  localparam int unsigned OSC_N  = 6;
  localparam int unsigned STAT_N = 7;

  // source codes
  localparam logic [SRC_W-1:0] SRC_EXT  = 3'h7;
  localparam logic [SRC_W-1:0] SRC_FAST = 3'h6;
  localparam logic [SRC_W-1:0] SRC_SLOW = 3'h5;
  localparam logic [SRC_W-1:0] SRC_SEC  = 3'h4;
  localparam logic [SRC_W-1:0] SRC_PLL  = 3'h2;

  // highest legal divider code, divide by 512
  localparam logic [DIV_W-1:0] DIV_MAX = 4'h9;

  // selection and frequency after reset
  localparam logic [SRC_W-1:0] RESET_SOURCE  = SRC_FAST;
  localparam logic [DIV_W-1:0] RESET_DIVIDER = 4'h0;
  localparam logic [FRQ_W-1:0] RESET_FREQ    = 4'h0;

  // bit positions in enable and ready vectors, OSC_PLL in the ready vector only
  localparam int unsigned OSC_EXT  = 0;
  localparam int unsigned OSC_FAST = 1;
  localparam int unsigned OSC_MED  = 2;
  localparam int unsigned OSC_SLOW = 3;
  localparam int unsigned OSC_SEC  = 4;
  localparam int unsigned OSC_ADC  = 5;
  localparam int unsigned OSC_PLL  = 6;

  // start-up timer length in oscillator periods
  localparam int unsigned OST_PERIODS = 1024;

  // synchroniser depth, and blanking of stale ready after a frequency write
  localparam int unsigned SYNC_STAGES       = 2;
  localparam int unsigned FREQ_BLANK_CYCLES = SYNC_STAGES + 1;
  localparam logic [1:0]  FREQ_BLANK_LOAD   = 2'(FREQ_BLANK_CYCLES);

  // switch sequencer
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_READY
  } scs_state_e;

endpackage : scs_pkg

// ---- scs_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module scs_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             en_i,
  // levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  // two flops per bit; the first is read only by the second
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      logic meta_reg;
      logic stable_reg;
      always_ff @(posedge clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          meta_reg   <= 1'b0;
          stable_reg <= 1'b0;
        end
        else if (en_i)
        begin
          meta_reg   <= async_i[g];
          stable_reg <= meta_reg;
        end
      end
      assign sync_o[g] = stable_reg;
    end
  endgenerate

endmodule : scs_sync
`default_nettype wire

// ---- scs_top.sv ----
// Behaviour
// - fast and medium ready flags set only when oscillator runs at accuracy
// - frequency select write clears both internal ready flags until ready again
// - medium clock held static while a frequency change is pending
// - ready status for every source and multiplier; manual enable cannot start multiplier
// - with switching not permitted, request writes are ignored
// - old selection drives clock until requested source reports ready
// - on ready set new-source-ready and irq flag; irq out when enabled
// - switch interrupt is never a wake-up from sleep
// - source codes: 7 ext, 6 fast, 5 slow, 4 secondary, 2 ext with multiplier
// - divider code n divides by two to the n, codes above 9 reserved
// - current fields change only at switch; then done set, new-ready cleared
// - with hold set, request accepted, new-ready set, switch not completed
// - with hold clear the switch completes once new-ready sets
// - multiplier source waits for source ready and multiplier lock
// - sleep entered before completion leaves the switch undone
// - wake with hold clear completes the switch and sets irq flag
// - wake with hold set stays on old clock and requests again
// - in doze the switch happens on the next clock cycle
// - irq flag stays set until software clears it
// - external ready only after start-up timer counted 1024 periods
`timescale 1ns/100ps
`default_nettype none
module scs_top
  import scs_pkg::*;
#(
  parameter int unsigned OST_LEN = scs_pkg::OST_PERIODS
) (
  // clock, reset, enable
  input  wire logic                         clk_i,
  input  wire logic                         rst_b_i,
  input  wire logic                         en_i,
  // configuration and control levels
  input  wire logic                         switch_permit_config_i,
  input  wire logic                         switch_hold_i,
  input  wire logic                         switch_irq_enable_i,
  input  wire logic [scs_pkg::OSC_N-1:0]    oscillator_manual_enable_i,
  // request write
  input  wire logic                         request_write_i,
  input  wire logic [scs_pkg::SRC_W-1:0]    requested_source_i,
  input  wire logic [scs_pkg::DIV_W-1:0]    requested_divider_i,
  // frequency select write
  input  wire logic                         freq_write_i,
  input  wire logic [scs_pkg::FRQ_W-1:0]    internal_frequency_select_i,
  // irq flag clear strobe
  input  wire logic                         switch_irq_clear_i,
  // power state, same clock domain
  input  wire logic                         sleep_i,
  input  wire logic                         doze_i,
  // raw oscillator pins and analog ready levels
  input  wire logic                         ext_osc_i,
  input  wire logic                         fast_accurate_i,
  input  wire logic                         medium_accurate_i,
  input  wire logic                         slow_running_i,
  input  wire logic                         sec_running_i,
  input  wire logic                         adc_rc_running_i,
  input  wire logic                         multiplier_locked_i,
  // selection fields
  output logic      [scs_pkg::SRC_W-1:0]    requested_source_o,
  output logic      [scs_pkg::DIV_W-1:0]    requested_divider_o,
  output logic      [scs_pkg::SRC_W-1:0]    current_source_o,
  output logic      [scs_pkg::DIV_W-1:0]    current_divider_o,
  output logic      [scs_pkg::FRQ_W-1:0]    internal_frequency_select_o,
  // flags and interrupt
  output logic                              new_source_ready_o,
  output logic                              switch_done_flag_o,
  output logic                              switch_irq_flag_o,
  output logic                              irq_o,
  // oscillator status and enables
  output logic      [scs_pkg::STAT_N-1:0]   oscillator_ready_status_o,
  output logic      [scs_pkg::OSC_N-1:0]    oscillator_enable_o,
  output logic                              multiplier_enable_o,
  output logic                              medium_run_o,
  // divided system clock enable
  output logic                              sys_clk_tick_o
);

  // synchronised analog levels and oscillator pin
  logic [6:0] raw_lvl;
  logic [6:0] syn_lvl;
  assign raw_lvl = {ext_osc_i, multiplier_locked_i, adc_rc_running_i, sec_running_i,
                    slow_running_i, medium_accurate_i, fast_accurate_i};

  scs_sync #(
    .WIDTH (7)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .en_i    (en_i),
    .async_i (raw_lvl),
    .sync_o  (syn_lvl)
  );

  logic fast_syn;
  logic med_syn;
  logic slow_syn;
  logic sec_syn;
  logic adc_syn;
  logic pll_syn;
  logic ext_syn;
  assign fast_syn = syn_lvl[0];
  assign med_syn  = syn_lvl[1];
  assign slow_syn = syn_lvl[2];
  assign sec_syn  = syn_lvl[3];
  assign adc_syn  = syn_lvl[4];
  assign pll_syn  = syn_lvl[5];
  assign ext_syn  = syn_lvl[6];

  // state
  scs_state_e       state_reg,    state_next;
  logic [SRC_W-1:0] req_src_reg,  req_src_next;
  logic [DIV_W-1:0] req_div_reg,  req_div_next;
  logic [SRC_W-1:0] cur_src_reg,  cur_src_next;
  logic [DIV_W-1:0] cur_div_reg,  cur_div_next;
  logic             nsr_reg,      nsr_next;
  logic             done_reg,     done_next;
  logic             irqf_reg,     irqf_next;
  logic             sleep_q_reg,  sleep_q_next;
  logic [FRQ_W-1:0] frq_reg,      frq_next;
  logic [1:0]       blank_reg,    blank_next;
  logic             fast_rdy_reg, fast_rdy_next;
  logic             med_rdy_reg,  med_rdy_next;
  logic             stall_reg,    stall_next;
  logic [8:0]       div_cnt_reg,  div_cnt_next;
  logic             tick_reg,     tick_next;

  // decoded conditions
  logic req_legal;
  logic req_take;
  logic req_differs;
  logic wake_edge;
  logic ext_wanted;
  logic ext_ready;
  logic ost_restart;
  logic target_ready;
  logic irq_set;

  // reserved source or divider codes never count as a request
  always_comb
  begin
    unique case (requested_source_i)
      SRC_EXT, SRC_FAST, SRC_SLOW, SRC_SEC, SRC_PLL: req_legal = (requested_divider_i <= DIV_MAX);
      default:                                        req_legal = 1'b0;
    endcase
  end

  assign req_take    = request_write_i && switch_permit_config_i && req_legal;
  assign req_differs = {requested_source_i, requested_divider_i} != {cur_src_reg, cur_div_reg};
  assign wake_edge   = sleep_q_reg && !sleep_i;

  // external oscillator runs when chosen, requested or forced on
  assign ext_wanted  = oscillator_manual_enable_i[OSC_EXT]
                    || cur_src_reg == SRC_EXT || cur_src_reg == SRC_PLL
                    || req_src_reg == SRC_EXT || req_src_reg == SRC_PLL;
  // timer restarts after wake or whenever the oscillator is stopped
  assign ost_restart = wake_edge || !ext_wanted;

  scs_ost #(
    .PERIODS (OST_LEN)
  ) u_ost (
    .clk_i      (clk_i),
    .rst_b_i    (rst_b_i),
    .en_i       (en_i),
    .osc_sync_i (ext_syn),
    .restart_i  (ost_restart),
    .done_o     (ext_ready)
  );

  // ready of the requested selection
  always_comb
  begin
    unique case (req_src_reg)
      SRC_EXT:  target_ready = ext_ready;
      SRC_FAST: target_ready = fast_rdy_reg;
      SRC_SLOW: target_ready = slow_syn;
      SRC_SEC:  target_ready = sec_syn;
      SRC_PLL:  target_ready = ext_ready && pll_syn;
      default:  target_ready = 1'b0;
    endcase
  end

  // switch sequencer; doze does not stall it, it only steps on clk
  always_comb
  begin
    state_next   = state_reg;
    req_src_next = req_src_reg;
    req_div_next = req_div_reg;
    cur_src_next = cur_src_reg;
    cur_div_next = cur_div_reg;
    nsr_next     = nsr_reg;
    done_next    = done_reg;
    sleep_q_next = sleep_i;
    irq_set      = 1'b0;
    if (req_take)
    begin
      req_src_next = requested_source_i;
      req_div_next = requested_divider_i;
      nsr_next     = 1'b0;
      // writing the current value back abandons a pending switch
      state_next   = req_differs ? ST_WAIT : ST_IDLE;
      if (req_differs)
        done_next = 1'b0;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
          state_next = ST_IDLE;
        end
        ST_WAIT:
        begin
          // old clock keeps running until the new one is ready
          if (target_ready && !sleep_i)
          begin
            nsr_next   = 1'b1;
            irq_set    = 1'b1;
            state_next = ST_READY;
          end
        end
        ST_READY:
        begin
          if (wake_edge && switch_hold_i)
          begin
            nsr_next   = 1'b0;
            state_next = ST_WAIT;
          end
          else if (!switch_hold_i && !sleep_i)
          begin
            cur_src_next = req_src_reg;
            cur_div_next = req_div_reg;
            done_next    = 1'b1;
            nsr_next     = 1'b0;
            irq_set      = wake_edge;
            state_next   = ST_IDLE;
          end
        end
      endcase
    end
    // set wins over a clear in the same cycle
    irqf_next = irq_set || (irqf_reg && !switch_irq_clear_i);
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_reg   <= ST_IDLE;
      req_src_reg <= RESET_SOURCE;
      req_div_reg <= RESET_DIVIDER;
      cur_src_reg <= RESET_SOURCE;
      cur_div_reg <= RESET_DIVIDER;
      nsr_reg     <= 1'b0;
      done_reg    <= 1'b0;
      irqf_reg    <= 1'b0;
      sleep_q_reg <= 1'b0;
    end
    else if (en_i)
    begin
      state_reg   <= state_next;
      req_src_reg <= req_src_next;
      req_div_reg <= req_div_next;
      cur_src_reg <= cur_src_next;
      cur_div_reg <= cur_div_next;
      nsr_reg     <= nsr_next;
      done_reg    <= done_next;
      irqf_reg    <= irqf_next;
      sleep_q_reg <= sleep_q_next;
    end
  end

  // internal frequency select; stale ready is blanked through the synchroniser delay
  always_comb
  begin
    frq_next      = frq_reg;
    blank_next    = blank_reg;
    fast_rdy_next = fast_rdy_reg;
    med_rdy_next  = med_rdy_reg;
    stall_next    = stall_reg;
    if (freq_write_i)
    begin
      frq_next      = internal_frequency_select_i;
      blank_next    = FREQ_BLANK_LOAD;
      fast_rdy_next = 1'b0;
      med_rdy_next  = 1'b0;
      stall_next    = 1'b1;
    end
    else if (blank_reg != 2'h0)
      blank_next = blank_reg - 2'h1;
    else
    begin
      fast_rdy_next = fast_syn;
      med_rdy_next  = med_syn;
      if (fast_syn)
        stall_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      frq_reg      <= RESET_FREQ;
      blank_reg    <= FREQ_BLANK_LOAD;
      fast_rdy_reg <= 1'b0;
      med_rdy_reg  <= 1'b0;
      stall_reg    <= 1'b1;
    end
    else if (en_i)
    begin
      frq_reg      <= frq_next;
      blank_reg    <= blank_next;
      fast_rdy_reg <= fast_rdy_next;
      med_rdy_reg  <= med_rdy_next;
      stall_reg    <= stall_next;
    end
  end

  // divided clock enable, one tick every two to the n cycles
  always_comb
  begin
    div_cnt_next = div_cnt_reg + 9'h001;
    tick_next    = 1'b0;
    if (div_cnt_reg >= 9'((1 << cur_div_reg) - 1))
    begin
      div_cnt_next = 9'h000;
      tick_next    = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      div_cnt_reg <= 9'h000;
      tick_reg    <= 1'b0;
    end
    else if (en_i)
    begin
      div_cnt_reg <= div_cnt_next;
      tick_reg    <= tick_next;
    end
  end

  // outputs
  assign requested_source_o          = req_src_reg;
  assign requested_divider_o         = req_div_reg;
  assign current_source_o            = cur_src_reg;
  assign current_divider_o           = cur_div_reg;
  assign internal_frequency_select_o = frq_reg;
  assign new_source_ready_o          = nsr_reg;
  assign switch_done_flag_o          = done_reg;
  assign switch_irq_flag_o           = irqf_reg;
  assign irq_o                       = irqf_reg && switch_irq_enable_i && !sleep_i;
  assign medium_run_o                = !stall_reg;
  assign sys_clk_tick_o              = tick_reg;
  assign oscillator_ready_status_o   = {pll_syn, adc_syn, sec_syn, slow_syn, med_rdy_reg, fast_rdy_reg, ext_ready};
  // manual enables reach oscillators only; the multiplier follows selection alone
  assign multiplier_enable_o         = (cur_src_reg == SRC_PLL) || (req_src_reg == SRC_PLL);
  assign oscillator_enable_o         = oscillator_manual_enable_i
                                    | {1'b0,
                                       cur_src_reg == SRC_SEC  || req_src_reg == SRC_SEC,
                                       cur_src_reg == SRC_SLOW || req_src_reg == SRC_SLOW,
                                       1'b0,
                                       cur_src_reg == SRC_FAST || req_src_reg == SRC_FAST,
                                       ext_wanted};

  // checks
  sequence s_ready_released;
    state_reg == ST_READY && !switch_hold_i && !sleep_i && !request_write_i && en_i;
  endsequence

  sequence s_selection_moved;
    $changed(cur_src_reg) || $changed(cur_div_reg);
  endsequence

  property p_irq_with_ready;
    @(posedge clk_i) disable iff (!rst_b_i) $rose(nsr_reg) |-> irqf_reg;
  endproperty
  a_irq_with_ready: assert property (p_irq_with_ready) else $error("irq flag not set with new ready");

  property p_no_irq_asleep;
    @(posedge clk_i) disable iff (!rst_b_i) sleep_i |-> !irq_o;
  endproperty
  a_no_irq_asleep: assert property (p_no_irq_asleep) else $error("irq driven during sleep");

  property p_move_only_at_switch;
    @(posedge clk_i) disable iff (!rst_b_i) s_selection_moved |-> $past(state_reg) == ST_READY && done_reg && !nsr_reg;
  endproperty
  a_move_only_at_switch: assert property (p_move_only_at_switch) else $error("current selection moved outside switch");

  property p_permit_blocks;
    @(posedge clk_i) disable iff (!rst_b_i)
      request_write_i && !switch_permit_config_i |=> $stable(req_src_reg) && $stable(req_div_reg);
  endproperty
  a_permit_blocks: assert property (p_permit_blocks) else $error("request taken while not permitted");

  property p_hold_keeps_old;
    @(posedge clk_i) disable iff (!rst_b_i) state_reg == ST_READY && switch_hold_i |=> $stable(cur_src_reg);
  endproperty
  a_hold_keeps_old: assert property (p_hold_keeps_old) else $error("switch completed under hold");

  property p_release_switches;
    @(posedge clk_i) disable iff (!rst_b_i)
      s_ready_released |=> cur_src_reg == $past(req_src_reg) && cur_div_reg == $past(req_div_reg) && done_reg;
  endproperty
  a_release_switches: assert property (p_release_switches) else $error("switch not completed next cycle");

  property p_freq_clears;
    @(posedge clk_i) disable iff (!rst_b_i) freq_write_i && en_i |=> !fast_rdy_reg && !med_rdy_reg && !medium_run_o;
  endproperty
  a_freq_clears: assert property (p_freq_clears) else $error("ready flags not cleared by frequency write");

  property p_irq_sticky;
    @(posedge clk_i) disable iff (!rst_b_i) irqf_reg && !switch_irq_clear_i |=> irqf_reg;
  endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("irq flag dropped without clear");

  property p_reserved_ignored;
    @(posedge clk_i) disable iff (!rst_b_i)
      request_write_i && !req_legal |=> $stable(req_src_reg) && $stable(req_div_reg)
                                        && !(state_reg == ST_WAIT && $past(state_reg) == ST_IDLE);
  endproperty
  a_reserved_ignored: assert property (p_reserved_ignored) else $error("reserved code taken as request");

  property p_pll_waits;
    @(posedge clk_i) disable iff (!rst_b_i) $rose(nsr_reg) && req_src_reg == SRC_PLL |-> $past(pll_syn) && $past(ext_ready);
  endproperty
  a_pll_waits: assert property (p_pll_waits) else $error("multiplier source ready without lock");

  // doze must not delay the switch by a single cycle
  property p_doze_no_stall;
    @(posedge clk_i) disable iff (!rst_b_i) s_ready_released ##0 doze_i |=> done_reg && !nsr_reg;
  endproperty
  a_doze_no_stall: assert property (p_doze_no_stall) else $error("switch delayed in doze");

endmodule : scs_top
`default_nettype wire

// ---- system_clock_switch_control_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module system_clock_switch_control_bench;
  import scs_pkg::*;
  // stimulus; strobes driven on the rising edge, levels on either edge
  logic       clk_i = 1'h0;
  logic       rst_b_i = 1'h0;
  logic       pm = 1'h1, hd = 1'h0, ie = 1'h1, rw = 1'h0, fw = 1'h0, cl = 1'h0, sl = 1'h0;
  logic       fok = 1'h1, sok = 1'h1, lok = 1'h1, lk = 1'h1, dz = 1'h0;
  logic [2:0] rso;
  logic [3:0] rdo;
  logic [1:0] xc = 2'h0;
  logic [5:0] man = 6'h00;
  logic [2:0] rs = 3'h0;
  logic [3:0] rd = 4'h0, fq = 4'h0;
  // observed outputs
  logic [2:0] cs;
  logic [3:0] cd, fqo;
  logic       nr, dn, fl, irq, me, mr, tk;
  logic [6:0] st;
  logic [5:0] oe;
  int         bad_count = 0, samples_checked = 0, cyc = 0, m_src, m_div, n;
  logic [2:0] srcs [4] = '{3'h7, 3'h6, 3'h5, 3'h4};

  scs_top #(.OST_LEN(8)) i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .en_i(1'h1),
    .switch_permit_config_i(pm), .switch_hold_i(hd), .switch_irq_enable_i(ie),
    .oscillator_manual_enable_i(man), .request_write_i(rw), .requested_source_i(rs),
    .requested_divider_i(rd), .freq_write_i(fw), .internal_frequency_select_i(fq),
    .switch_irq_clear_i(cl), .sleep_i(sl), .doze_i(dz), .ext_osc_i(xc[1]),
    .fast_accurate_i(fok), .medium_accurate_i(fok), .slow_running_i(lok),
    .sec_running_i(sok), .adc_rc_running_i(1'h1), .multiplier_locked_i(lk),
    .requested_source_o(rso), .requested_divider_o(rdo), .current_source_o(cs),
    .current_divider_o(cd), .internal_frequency_select_o(fqo), .new_source_ready_o(nr),
    .switch_done_flag_o(dn), .switch_irq_flag_o(fl), .irq_o(irq),
    .oscillator_ready_status_o(st), .oscillator_enable_o(oe),
    .multiplier_enable_o(me), .medium_run_o(mr), .sys_clk_tick_o(tk));

  // free-running clock, and an external oscillator at a quarter rate
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) xc <= xc + 2'h1;

  // hang guard, well above the longest expected run
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      bad_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checked=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic got, input logic exp);
    chk_val({15'h0000, got}, {15'h0000, exp});
  endtask : chk_bit

  task automatic gap(input int k);
    repeat (k) @(negedge clk_i);
  endtask : gap

  // one-cycle request strobe, fields held with it
  task automatic req(input logic [2:0] s, input logic [3:0] d);
    @(posedge clk_i);
    rw <= 1'h1;
    rs <= s;
    rd <= d;
    @(posedge clk_i);
    rw <= 1'h0;
  endtask : req

  // bounded wait on a flag, sampled away from the edge
  task automatic wait_bit(ref logic s);
    n = 0;
    while (s !== 1'h1 && n < 2000)
    begin
      @(negedge clk_i);
      n++;
    end
    chk_bit(s, 1'h1);
  endtask : wait_bit

  // model of the selection, compared with the current fields
  task automatic chk_cur();
    chk_val(16'(cs), 16'(m_src));
    chk_val(16'(cd), 16'(m_div));
  endtask : chk_cur

  task automatic sw(input logic [2:0] s, input logic [3:0] d);
    dz <= 1'($urandom_range(1));
    req(s, d);
    gap(1);
    chk_cur();
    m_src = s;
    m_div = d;
    chk_val(16'({rso, rdo}), 16'({s, d}));
    wait_bit(dn);
    chk_cur();
    chk_bit(nr, 1'h0);
    chk_bit(fl, 1'h1);
  endtask : sw

  initial
  begin
    void'($urandom(32'h6f0d));
    m_src = RESET_SOURCE;
    m_div = RESET_DIVIDER;
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'h1;
    gap(8);
    chk_cur();
    chk_bit(fl, 1'h0);
    // frequency write blanks both internal ready flags and stalls the medium clock
    @(posedge clk_i);
    fw <= 1'h1;
    fq <= 4'($urandom_range(15));
    @(posedge clk_i);
    fw <= 1'h0;
    gap(2);
    chk_val(16'(fqo), 16'(fq));
    chk_val(16'(st[2:1]), 16'h0000);
    chk_bit(mr, 1'h0);
    gap(12);
    chk_val(16'(st[2:1]), 16'h0003);
    chk_bit(mr, 1'h1);
    // every switchable source except the multiplier, with a random, always differing divider
    foreach (srcs[i])
    begin
      sw(srcs[i], 4'((m_div + 1 + $urandom_range(8)) % 10));
      wait_bit(tk);
      n = 0;
      do
      begin
        @(negedge clk_i);
        n++;
      end while (tk !== 1'h1 && n < 1024);
      chk_val(16'(n), 16'(1 << m_div));
    end
    chk_bit(irq, 1'h1);
    @(posedge clk_i);
    cl <= 1'h1;
    @(posedge clk_i);
    cl <= 1'h0;
    gap(2);
    chk_bit(fl, 1'h0);
    chk_bit(irq, 1'h0);
    // locked configuration, then reserved codes: nothing may move
    pm <= 1'h0;
    req(3'h5, 4'h0);
    pm <= 1'h1;
    req(3'h0, 4'h0);
    req(3'h1, 4'h1);
    req(3'h3, 4'h2);
    req(3'h5, 4'(10 + $urandom_range(5)));
    gap(20);
    chk_cur();
    chk_val(16'({rso, rdo}), 16'({m_src[2:0], m_div[3:0]}));
    chk_bit(fl, 1'h0);
    // held switch completes only after the hold drops
    hd <= 1'h1;
    req(3'h5, 4'(m_div));
    wait_bit(nr);
    gap(5);
    chk_cur();
    hd <= 1'h0;
    m_src = 5;
    wait_bit(dn);
    chk_cur();
    // held switch abandoned by writing the current source back
    @(posedge clk_i);
    cl <= 1'h1;
    hd <= 1'h1;
    @(posedge clk_i);
    cl <= 1'h0;
    req(3'h6, 4'(m_div));
    wait_bit(nr);
    req(3'h5, 4'(m_div));
    hd <= 1'h0;
    gap(6);
    chk_cur();
    chk_bit(nr, 1'h0);
    chk_bit(fl, 1'h1);
    // manual enables never start the multiplier
    man <= 6'h3F;
    gap(3);
    chk_val(16'(oe), 16'h003F);
    chk_bit(me, 1'h0);
    man <= 6'h00;
    // multiplier source waits for the lock as well
    lk <= 1'h0;
    req(3'h2, 4'(m_div));
    gap(8);
    chk_bit(st[OSC_EXT], 1'h0);
    gap(52);
    chk_cur();
    chk_bit(st[OSC_EXT], 1'h1);
    lk <= 1'h1;
    m_src = 2;
    wait_bit(dn);
    chk_cur();
    chk_bit(st[OSC_PLL], 1'h1);
    // sleep before the target is ready, completion on wake
    sok <= 1'h0;
    req(3'h4, 4'(m_div));
    sl <= 1'h1;
    sok <= 1'h1;
    gap(20);
    chk_cur();
    chk_bit(irq, 1'h0);
    // flag cleared while asleep, so only the wake can set it again
    @(posedge clk_i);
    cl <= 1'h1;
    @(posedge clk_i);
    cl <= 1'h0;
    sl <= 1'h0;
    m_src = 4;
    wait_bit(dn);
    chk_cur();
    chk_bit(fl, 1'h1);
    chk_bit(irq, 1'h1);
    // wake under hold drops new-ready for a cycle and asks again on the old clock
    hd <= 1'h1;
    req(3'h5, 4'(m_div));
    wait_bit(nr);
    sl <= 1'h1;
    gap(4);
    sl <= 1'h0;
    gap(1);
    chk_bit(nr, 1'h0);
    wait_bit(nr);
    chk_cur();
    hd <= 1'h0;
    m_src = 5;
    wait_bit(dn);
    chk_cur();
    final_report();
  end
endmodule : system_clock_switch_control_bench
`default_nettype wire
